// [logic/mfa_top.sv]
`timescale 1ns/1ps
// ==========================================================
// mode-dependent reset and fault alert pins
module mfa_top (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic control_source_strap_i,
  input wire logic reset_pin_n_i,
  input wire logic open_load_i,
  input wire logic short_load_i,
  input wire logic over_temp_i,
  input wire logic packet_check_err_i,
  output logic fault_alert_o,
  output logic fault_alert_oe_n_o,
  output logic open_loop_alert_o,
  output logic open_loop_alert_oe_n_o,
  output logic hw_mode_o,
  output logic soft_reset_n_o
);
  mfa_pkg::mfa_mode_t mode_r;
  mfa_pkg::mfa_mode_t mode_nxt;
  logic latched_r;
  logic latched_nxt;
  logic soft_rst_r;
  logic soft_rst_nxt;
  logic block_rst_n;
  logic fault_cause;
  logic open_cause;

  // ==========================================================
  // strap capture, once after reset release
  always_comb begin
    mode_nxt = mode_r;
    latched_nxt = 1'h1;
    if (!latched_r) begin
      if (control_source_strap_i == mfa_pkg::MFA_STRAP_SW) begin
        mode_nxt = mfa_pkg::MFA_MODE_SW;
      end else begin
        mode_nxt = mfa_pkg::MFA_MODE_HW;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r <= mfa_pkg::MFA_MODE_SW;
      latched_r <= 1'h0;
    end else begin
      mode_r <= mode_nxt;
      latched_r <= latched_nxt;
    end
  end

  // ==========================================================
  // reset pin, honoured only in software mode
  always_comb begin
    soft_rst_nxt = 1'h0;
    // software mode reset
    // mode is only trusted once latched, so a strapped-high part never sees a reset pulse
    if (latched_r && mode_r == mfa_pkg::MFA_MODE_SW && !reset_pin_n_i) begin
      soft_rst_nxt = 1'h1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      soft_rst_r <= 1'h0;
    end else begin
      soft_rst_r <= soft_rst_nxt;
    end
  end

  // internal reset for alert logic; mode strap stays latched
  assign block_rst_n = rst_n_i & ~soft_rst_r;

  // ==========================================================
  // alert cause selection per mode
  always_comb begin
    fault_cause = 1'h0;
    open_cause = 1'h0;
    if (mode_r == mfa_pkg::MFA_MODE_SW) begin
      fault_cause = open_load_i | short_load_i | over_temp_i | packet_check_err_i;
      open_cause = 1'h0;
    end else begin
      fault_cause = over_temp_i;
      open_cause = open_load_i;
    end
  end

  mfa_alert_drv u_fault (
    .clock_i(clock_i),
    .rst_n_i(block_rst_n),
    .cause_i(fault_cause),
    .oe_n_o(fault_alert_oe_n_o),
    .flag_o()
  );

  mfa_alert_drv u_open (
    .clock_i(clock_i),
    .rst_n_i(block_rst_n),
    .cause_i(open_cause),
    .oe_n_o(open_loop_alert_oe_n_o),
    .flag_o()
  );

  // open-drain: output value is always low
  assign fault_alert_o = 1'h0;
  assign open_loop_alert_o = 1'h0;
  assign hw_mode_o = (mode_r == mfa_pkg::MFA_MODE_HW);
  assign soft_reset_n_o = ~soft_rst_r;

  // ==========================================================
  // checks
  // software combined alert
  sw_fault_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (latched_r && mode_r == mfa_pkg::MFA_MODE_SW && !soft_rst_r && short_load_i
     && reset_pin_n_i) |=> !fault_alert_oe_n_o
  ) else $error("sw fault missed");

  sw_temp_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (latched_r && mode_r == mfa_pkg::MFA_MODE_SW && !soft_rst_r && over_temp_i
     && reset_pin_n_i) |=> !fault_alert_oe_n_o
  ) else $error("sw temp missed");

  sw_clear_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (latched_r && mode_r == mfa_pkg::MFA_MODE_SW
     && !(open_load_i | short_load_i | over_temp_i | packet_check_err_i))
    |=> fault_alert_oe_n_o
  ) else $error("sw alert not released");

  hw_temp_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (mode_r == mfa_pkg::MFA_MODE_HW && $past(mode_r) == mfa_pkg::MFA_MODE_HW
     && !over_temp_i) |=> fault_alert_oe_n_o
  ) else $error("hw alert not temp only");

  hw_temp_set_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (mode_r == mfa_pkg::MFA_MODE_HW && over_temp_i) |=> !fault_alert_oe_n_o
  ) else $error("hw temp missed");

  hw_open_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (mode_r == mfa_pkg::MFA_MODE_HW && open_load_i) |=> !open_loop_alert_oe_n_o
  ) else $error("open loop missed");

  hw_open_clr_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (mode_r == mfa_pkg::MFA_MODE_HW && !open_load_i) |=> open_loop_alert_oe_n_o
  ) else $error("open loop not released");

  sw_open_idle_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (mode_r == mfa_pkg::MFA_MODE_SW) |=> open_loop_alert_oe_n_o
  ) else $error("open pin active in sw");

  sw_reset_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (latched_r && mode_r == mfa_pkg::MFA_MODE_SW && !reset_pin_n_i) |=> !soft_reset_n_o ##1
    (fault_alert_oe_n_o || !soft_reset_n_o)
  ) else $error("sw reset ignored");

  sw_rst_release_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (latched_r && mode_r == mfa_pkg::MFA_MODE_SW && reset_pin_n_i) |=> soft_reset_n_o
  ) else $error("sw reset stuck");

  hw_no_reset_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (mode_r == mfa_pkg::MFA_MODE_HW) |=> soft_reset_n_o
  ) else $error("hw reset acted");

  strap_sw_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (!latched_r && !control_source_strap_i) |=> !hw_mode_o ##1 !hw_mode_o
  ) else $error("strap sw wrong");

  strap_hw_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (!latched_r && control_source_strap_i) |=> hw_mode_o [*3]
  ) else $error("strap hw wrong");

  mode_hold_a: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    latched_r |=> (hw_mode_o == $past(hw_mode_o))
  ) else $error("mode changed after latch");

  // main scenarios reached
  sw_fault_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_r == mfa_pkg::MFA_MODE_SW && !fault_alert_oe_n_o);
  hw_open_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_r == mfa_pkg::MFA_MODE_HW && !open_loop_alert_oe_n_o);
  sw_reset_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    !soft_reset_n_o);
  hw_temp_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_r == mfa_pkg::MFA_MODE_HW && !fault_alert_oe_n_o);
  hw_ignore_c: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    mode_r == mfa_pkg::MFA_MODE_HW && !reset_pin_n_i);
endmodule : mfa_top

// [logic/mfa_pkg.sv]
// Summary of operation
// - A strap sampled at 0 selects software control.
// - A strap sampled at 1 selects hardware control with configuration from pins.
// - In software mode a low reset input returns the alert logic to its power-on state; the mode strap stays latched.
// - In hardware mode the reset input is ignored and the host should hold it high.
// - Software mode: shared alert low on open load, short load, overheat, packet_check error.
// - In hardware mode the shared alert shows only overtemperature.
// - In hardware mode the open-loop alert goes low on an open current loop.
// - In software mode the open-loop pin has no function and the host grounds it.
package mfa_pkg;
  // ==========================================================
  // mode encoding and reset values
  typedef enum logic [1:0] {
    MFA_MODE_SW = 2'h1,
    MFA_MODE_HW = 2'h2
  } mfa_mode_t;
  localparam logic MFA_STRAP_SW = 1'h0;
  localparam logic MFA_FLAG_RST = 1'h0;
  localparam logic MFA_OE_N_RST = 1'h1;
  localparam int MFA_SYNC_CYC = 1;
endpackage : mfa_pkg

// [logic/mfa_alert_drv.sv]
`timescale 1ns/1ps
// ==========================================================
// one open-drain alert: registered active-high flag to output enable
module mfa_alert_drv (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic cause_i,
  output logic oe_n_o,
  output logic flag_o
);
  logic flag_r;
  logic flag_nxt;

  // follow and release
  // follows its cause, released when cause clears
  always_comb begin
    flag_nxt = cause_i;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_r <= mfa_pkg::MFA_FLAG_RST;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // pin pulled low while enable low
  assign oe_n_o = ~flag_r;
  assign flag_o = flag_r;

  release_track_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !cause_i |=> !flag_r) else $error("alert not released");
  set_track_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    cause_i |=> !oe_n_o) else $error("alert not asserted");
endmodule : mfa_alert_drv

// [verif/mfa_host.sv]
`timescale 1ns/1ps
// ==========================================================
// host side: pull-up on the fault pin and, in hardware mode only, on the open-loop pin; drives the reset pin
module mfa_host (
  input wire logic strap_i,
  input wire logic break_i,
  input wire logic req_n_i,
  input wire logic fault_data_i,
  input wire logic fault_oe_n_i,
  input wire logic ol_data_i,
  input wire logic ol_oe_n_i,
  output logic reset_pin_n_o,
  output logic fault_pin_o,
  output logic ol_pin_o
);
  // reset held high in hardware mode unless break_i probes that it is ignored
  assign reset_pin_n_o = (strap_i & ~break_i) | req_n_i;
  // pull-up releases the fault pin
  assign fault_pin_o = fault_oe_n_i ? 1'h1 : fault_data_i;
  // open-loop pin grounded in software mode
  assign ol_pin_o = strap_i ? (ol_oe_n_i ? 1'h1 : ol_data_i) : 1'h0;
endmodule : mfa_host

// [verif/tb.sv]
`timescale 1ns/1ps
// ==========================================================
// bench: random causes, queued expectations
module tb;
  logic clock_i = 1'h0, rst_n_i = 1'h0, strap = 1'h0, brk = 1'h0, req_n = 1'h1;
  logic [3:0] cause = 4'h0;  // temp, packet_check, short, open
  logic [7:0] lf = 8'h1c;
  logic f_d, f_oe, o_d, o_oe, hw, srn, rp, fp, op, prev_rp;
  logic [3:0] q[$];  // care, soft reset, fault pin, open-loop enable
  logic [3:0] e;
  int errors = 0, cmp_count = 0;
  mfa_top i_mfa_top (.clock_i(clock_i), .rst_n_i(rst_n_i), .control_source_strap_i(strap),
    .reset_pin_n_i(rp), .open_load_i(cause[0]), .short_load_i(cause[1]),
    .over_temp_i(cause[3]), .packet_check_err_i(cause[2]), .fault_alert_o(f_d),
    .fault_alert_oe_n_o(f_oe), .open_loop_alert_o(o_d), .open_loop_alert_oe_n_o(o_oe),
    .hw_mode_o(hw), .soft_reset_n_o(srn));
  mfa_host i_mfa_host (.strap_i(strap), .break_i(brk), .req_n_i(req_n), .fault_data_i(f_d),
    .fault_oe_n_i(f_oe), .ol_data_i(o_d), .ol_oe_n_i(o_oe), .reset_pin_n_o(rp),
    .fault_pin_o(fp), .ol_pin_o(op));
  // clock
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  task automatic chk(input logic s, input logic x);
    cmp_count++;
    if (s !== x) begin
      errors++;
      $display("BAD %0t output mismatch", $time);
    end
  endtask : chk
  task tally_and_finish;
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // one mode phase: reset, latch strap, random traffic
  task automatic run(input logic s);
    @(posedge clock_i);
    rst_n_i <= 1'h0;
    strap <= s;
    brk <= s;
    req_n <= 1'h1;
    repeat (3) @(posedge clock_i);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge clock_i);
    prev_rp = 1'h1;
    for (int i = 0; i < 300; i++) begin
      @(posedge clock_i);
      if (strap) q.push_back({1'h1, 1'h1, ~cause[3], ~cause[0]});
      else if (!rp) q.push_back(4'hb);
      else q.push_back({prev_rp, 1'h1, ~|cause, 1'h1});
      prev_rp = rp;
      lf = lfsr(lf);
      cause <= lf[3:0];
      req_n <= lf[7] | lf[6];
    end
  endtask : run
  // monitor: compare settled outputs with the oldest note
  always @(negedge clock_i) begin
    if (q.size() > 0) begin
      e = q.pop_front();
      chk(hw, strap);
      chk(srn, e[2]);
      if (e[3]) begin
        chk(fp, e[1]);
        chk(o_oe, e[0]);
        chk(op, strap ? e[0] : 1'h0);
      end
    end
  end
  // watchdog
  initial begin
    #20000;
    errors++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    run(1'h0);
    run(1'h1);
    repeat (2) @(negedge clock_i);
    tally_and_finish();
  end
endmodule : tb
